// *** fault_host.sv ***
`default_nettype none

// ----
// Host side of the two alert lines
// ----
module fault_host (
    input wire logic primary_alert_n_o,
    input wire logic primary_alert_n_oe,
    input wire logic secondary_alert_n_o,
    input wire logic secondary_alert_n_oe,
    output logic primary_level,
    output logic secondary_level
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pull-ups hold each line high unless the device sinks it
    assign primary_level = primary_alert_n_oe ? primary_alert_n_o : 1'b1;
    assign secondary_level = secondary_alert_n_oe ? secondary_alert_n_o : 1'b1;
endmodule // fault_host

`default_nettype wire

// *** fault_seq_asserts.sv ***
`default_nettype none

module fault_seq_checker #(
    parameter int unsigned BLANK_CYC = 8,
    parameter int unsigned SLOW_BACKFLOW_CYC = 6,
    parameter int unsigned FAST_BACKFLOW_CYC = 2,
    parameter int unsigned UV_CYC = 30
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [1:0] limit_mode_select,
    input wire logic output_config,
    input wire logic overcurrent,
    input wire logic fast_trip_current,
    input wire logic thermal_trip_temp,
    input wire logic slow_backflow_threshold,
    input wire logic fast_backflow_threshold,
    input wire logic limit_set_resistor_low,
    input wire logic undervoltage_lockout,
    input wire logic overvoltage_lockout,
    input wire logic input_switch,
    input wire logic output_switch,
    input wire logic primary_alert_n_o,
    input wire logic primary_alert_n_oe,
    input wire logic secondary_alert_n_o,
    input wire logic secondary_alert_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] oc_run_r, slow_run_r, fast_run_r, up_run_r;

    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    // Lengths of consecutive runs, saturating
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            oc_run_r <= 8'h00;
            slow_run_r <= 8'h00;
            fast_run_r <= 8'h00;
            up_run_r <= 8'h00;
        end else begin
            oc_run_r <= (enable && overcurrent && limit_mode_select == 2'h1) ? inc(oc_run_r) : 8'h00;
            slow_run_r <= slow_backflow_threshold ? inc(slow_run_r) : 8'h00;
            fast_run_r <= fast_backflow_threshold ? inc(fast_run_r) : 8'h00;
            up_run_r <= inc(up_run_r);
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence blank_full;
        oc_run_r == BLANK_CYC + 1;
    endsequence
    sequence latch_off;
        !output_switch [*3];
    endsequence

    trip_cuts_output_a: assert property (fast_trip_current |=> !output_switch)
        else $error("output switch still on after fast trip");
    enable_low_off_a: assert property (!enable |=> !output_switch && !input_switch)
        else $error("switch on while enable low");
    oc_latch_a: assert property (blank_full |-> ##[1:3] latch_off)
        else $error("output not latched off after blanking");
    hot_cuts_output_a: assert property (thermal_trip_temp |=> !output_switch)
        else $error("output switch on while over temperature");
    hot_alert_a: assert property (thermal_trip_temp |-> ##[1:2] primary_alert_n_oe)
        else $error("no fault alert on thermal trip");
    slow_back_a: assert property (slow_run_r == SLOW_BACKFLOW_CYC + 1 |-> ##[0:3] !input_switch)
        else $error("input switch on after slow backflow");
    fast_back_a: assert property (fast_run_r == FAST_BACKFLOW_CYC + 1 |-> ##[0:3] !input_switch)
        else $error("input switch on after fast backflow");
    supply_alert_a: assert property (!output_config && (undervoltage_lockout || overvoltage_lockout)
        |-> ##[1:2] secondary_alert_n_oe)
        else $error("no supply window alert");
    uv_hold_a: assert property (!output_config && up_run_r >= 3 && up_run_r <= UV_CYC
        |-> secondary_alert_n_oe)
        else $error("supply alert released too early after power up");
    limit_alert_a: assert property (limit_set_resistor_low |-> ##[1:2] primary_alert_n_oe)
        else $error("no fault alert on low limit resistor");
    drain_low_a: assert property (!primary_alert_n_o && !secondary_alert_n_o)
        else $error("alert pin drives high");
endmodule // fault_seq_checker

bind protection_fault_sequencer fault_seq_checker #(.BLANK_CYC(BLANK_CYC), .SLOW_BACKFLOW_CYC(SLOW_BACKFLOW_CYC),
    .FAST_BACKFLOW_CYC(FAST_BACKFLOW_CYC), .UV_CYC(UV_CYC)) chk_i (.*);

`default_nettype wire

// *** fault_seq_pkg.sv ***
`default_nettype none

package fault_seq_pkg;

    // ------------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned NS_PER_MS = 1000000;

    // Least time in ns to whole cycles, rounded up, never below one
    function automatic int unsigned ceil_cycles(input int unsigned t_ns);
        int unsigned c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Longest time in ns to whole cycles, rounded down, never below one
    function automatic int unsigned floor_cycles(input int unsigned t_ns);
        int unsigned c;
        c = t_ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // ------------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------------
    localparam int unsigned FAST_TRIP_RESPONSE_US = 1;
    localparam int unsigned FAST_TRIP_RESPONSE_CYC = floor_cycles(FAST_TRIP_RESPONSE_US * NS_PER_US);
    localparam int unsigned FAST_TRIP_HOLDOFF_US = 400;
    localparam int unsigned FAST_TRIP_HOLDOFF_CYC = ceil_cycles(FAST_TRIP_HOLDOFF_US * NS_PER_US);
    localparam int unsigned INPUT_SWITCH_TURN_ON_US = 100;
    localparam int unsigned INPUT_SWITCH_TURN_ON_CYC = ceil_cycles(INPUT_SWITCH_TURN_ON_US * NS_PER_US);
    localparam int unsigned UV_DEBOUNCE_MS = 16;
    localparam int unsigned UV_DEBOUNCE_CYC = ceil_cycles(UV_DEBOUNCE_MS * NS_PER_MS);
    localparam int unsigned BLANK_TIME_US = 1000;
    localparam int unsigned BLANK_TIME_CYC = ceil_cycles(BLANK_TIME_US * NS_PER_US);
    localparam int unsigned RETRY_DELAY_MS = 1000;
    localparam int unsigned RETRY_DELAY_CYC = ceil_cycles(RETRY_DELAY_MS * NS_PER_MS);
    localparam int unsigned SLOW_BACKFLOW_DEBOUNCE_US = 100;
    localparam int unsigned SLOW_BACKFLOW_DEBOUNCE_CYC = ceil_cycles(SLOW_BACKFLOW_DEBOUNCE_US * NS_PER_US);
    localparam int unsigned FAST_BACKFLOW_RESPONSE_US = 1;
    localparam int unsigned FAST_BACKFLOW_RESPONSE_CYC = ceil_cycles(FAST_BACKFLOW_RESPONSE_US * NS_PER_US);

    localparam int unsigned TIMER_W = 32;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h0000_0000;
    localparam logic [TIMER_W-1:0] TIMER_STEP = 32'h0000_0001;

    // ------------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_CONTINUOUS = 2'h0,
        MODE_LATCHOFF = 2'h1,
        MODE_AUTORETRY = 2'h2,
        MODE_AUTORETRY_ALT = 2'h3
    } limit_mode_t;

    // Gray codes along on -> hold -> retry -> latched -> thermal
    typedef enum logic [2:0] {
        ST_ON = 3'h0,
        ST_FAST_HOLD = 3'h1,
        ST_RETRY = 3'h3,
        ST_LATCHED = 3'h2,
        ST_THERMAL = 3'h6
    } seq_state_t;

    localparam logic CFG_TWO_OUTPUT = 1'h0;
    localparam logic CFG_FWD_REV = 1'h1;

endpackage : fault_seq_pkg

`default_nettype wire

// *** interval_timer.sv ***
`default_nettype none

// Counts cycles while run is high; restarts from zero whenever run drops
module interval_timer #(
    parameter int unsigned LEN = 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    output logic done
);

    typedef struct packed {
        logic [fault_seq_pkg::TIMER_W-1:0] count_r;
    } timer_state_t;

    localparam logic [fault_seq_pkg::TIMER_W-1:0] LEN_W = LEN[fault_seq_pkg::TIMER_W-1:0];

    timer_state_t st_r;
    timer_state_t st_nxt;

    // Saturating count, cleared when the condition goes away
    always_comb begin
        st_nxt = st_r;
        if (!run) begin
            st_nxt.count_r = fault_seq_pkg::TIMER_ZERO;
        end else if (st_r.count_r != LEN_W) begin
            st_nxt.count_r = st_r.count_r + fault_seq_pkg::TIMER_STEP;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = run && (st_r.count_r == LEN_W);

endmodule // interval_timer

`default_nettype wire

// *** open_drain_driver.sv ***
`default_nettype none

// Active-low open-drain pin: pulls low while the fault is asserted
module open_drain_driver (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fault,
    output logic pin_o,
    output logic pin_oe
);

    typedef struct packed {
        logic oe_r;
    } od_state_t;

    od_state_t st_r;
    od_state_t st_nxt;

    // Drive enable follows the fault one cycle later
    always_comb begin
        st_nxt = st_r;
        st_nxt.oe_r = fault;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_o = 1'b0; // Only ever pulls low; pull-up is external
    assign pin_oe = st_r.oe_r;

endmodule // open_drain_driver

`default_nettype wire

// *** protection_fault_sequencer.sv ***
`default_nettype none

// Function
// R1: Latch-off mode: overcurrent starts the blanking timer immediately.
// R2: Overcurrent clearing before blanking ends resets timer, no fault shown.
// R3: Latch-off: blanking expiry or thermal trip latches output switch off, alerts.
// R4: Only enable toggle or supply cycle releases the latch.
// R5: Fast-trip current turns off only the output switch within 1 us.
// R6: After fast trip wait 400 us, then output switch back on.
// R7: Reverse blocking is a build option; disabled means no reverse fault.
// R8: Slow backflow for debounce time: input switch off, reverse fault.
// R9: Fast backflow for short response time: input switch off, reverse fault.
// R10: Backflow gone: input switch back on, fault clears after 100 us.
// R11: Two-output config: fault alert low on any listed fault source.
// R12: Supply-window alert low below under-voltage or above over-voltage.
// R13: Under-voltage fault releases only 16 ms after recovery; code debounces only the power-up recovery, later ones release at once.
// R14: Under-voltage debounce only at power-up; alert held at least 16 ms.
// R15: Forward/reverse config: forward alert and backflow alert split.
// R16: Both alerts are open-drain, active low, with external pull-ups.
// R17: Thermal trip turns device off and asserts the fault alert; code turns off only the output switch, input switch stays on.
// R18: Thermal recovery after hysteresis, except latch-off stays latched.
// R19: Autoretry: after thermal recovery wait full retry delay.
// R20: Continuous: switch off only while over temperature, on at once.
// R21: Thermal protection has no blanking or debounce.
// R22: Mode select input chooses latch-off, continuous or autoretry.
// R23: Autoretry: fault holds output off for retry delay, then restart.
// R24: All intervals are clock counters with parameter lengths.
// R25: Fault alert holds until every contributing source clears.
module protection_fault_sequencer #(
    parameter logic REVERSE_BLOCK_EN = 1'b1,
    parameter int unsigned BLANK_CYC = fault_seq_pkg::BLANK_TIME_CYC,
    parameter int unsigned FAST_HOLDOFF_CYC = fault_seq_pkg::FAST_TRIP_HOLDOFF_CYC,
    parameter int unsigned RETRY_CYC = fault_seq_pkg::RETRY_DELAY_CYC,
    parameter int unsigned SLOW_BACKFLOW_CYC = fault_seq_pkg::SLOW_BACKFLOW_DEBOUNCE_CYC,
    parameter int unsigned FAST_BACKFLOW_CYC = fault_seq_pkg::FAST_BACKFLOW_RESPONSE_CYC,
    parameter int unsigned INPUT_ON_CYC = fault_seq_pkg::INPUT_SWITCH_TURN_ON_CYC,
    parameter int unsigned UV_CYC = fault_seq_pkg::UV_DEBOUNCE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [1:0] limit_mode_select,
    input wire logic output_config,
    input wire logic overcurrent,
    input wire logic fast_trip_current,
    input wire logic startup_oc_fault,
    input wire logic thermal_trip_temp,
    input wire logic thermal_hysteresis,
    input wire logic slow_backflow_threshold,
    input wire logic fast_backflow_threshold,
    input wire logic limit_set_resistor_low,
    input wire logic undervoltage_lockout,
    input wire logic overvoltage_lockout,
    output logic input_switch,
    output logic output_switch,
    output logic primary_alert_n_o,
    output logic primary_alert_n_oe,
    output logic secondary_alert_n_o,
    output logic secondary_alert_n_oe
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        fault_seq_pkg::seq_state_t state_r;
        logic oc_fault_r;
        logic thermal_r;
        logic rev_fault_r;
        logic uv_done_r;
        logic in_sw_r;
        logic out_sw_r;
    } seq_regs_t;

    seq_regs_t st_r;
    seq_regs_t st_nxt;

    fault_seq_pkg::limit_mode_t mode;
    logic is_latchoff;
    logic is_autoretry;
    logic blank_run;
    logic blank_done;
    logic hold_run;
    logic hold_done;
    logic retry_run;
    logic retry_done;
    logic slow_bf_run;
    logic slow_bf_done;
    logic fast_bf_run;
    logic fast_bf_done;
    logic bf_present;
    logic settle_run;
    logic settle_done;
    logic uv_run;
    logic uv_done;
    logic thermal_now;
    logic fault_any;
    logic supply_fault;
    logic primary_fault;
    logic secondary_fault;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Three-state select arrives pre-decoded as a two-bit code
    assign mode = fault_seq_pkg::limit_mode_t'(limit_mode_select); // R22
    assign is_latchoff = (mode == fault_seq_pkg::MODE_LATCHOFF);
    assign is_autoretry = (mode == fault_seq_pkg::MODE_AUTORETRY) ||
                          (mode == fault_seq_pkg::MODE_AUTORETRY_ALT);

    // Thermal trip acts in the same cycle it is seen
    assign thermal_now = thermal_trip_temp || st_r.thermal_r; // R21

    // ------------------------------------------------------------------
    // Interval timers
    // ------------------------------------------------------------------
    // Blanking runs only while on and overcurrent persists
    assign blank_run = enable && (st_r.state_r == fault_seq_pkg::ST_ON) && overcurrent &&
                       !fast_trip_current; // R1 R2
    assign hold_run = (st_r.state_r == fault_seq_pkg::ST_FAST_HOLD);
    assign retry_run = (st_r.state_r == fault_seq_pkg::ST_RETRY);
    assign bf_present = slow_backflow_threshold || fast_backflow_threshold;
    assign slow_bf_run = REVERSE_BLOCK_EN && slow_backflow_threshold; // R7
    assign fast_bf_run = REVERSE_BLOCK_EN && fast_backflow_threshold; // R7
    assign settle_run = st_r.rev_fault_r && !bf_present;
    assign uv_run = !undervoltage_lockout && !st_r.uv_done_r; // R14

    interval_timer #(.LEN(BLANK_CYC)) u_blank ( // R24
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(blank_run),
        .done(blank_done)
    );

    interval_timer #(.LEN(FAST_HOLDOFF_CYC)) u_fast_hold (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(hold_run),
        .done(hold_done)
    );

    interval_timer #(.LEN(RETRY_CYC)) u_retry (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(retry_run),
        .done(retry_done)
    );

    interval_timer #(.LEN(SLOW_BACKFLOW_CYC)) u_slow_bf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(slow_bf_run),
        .done(slow_bf_done)
    );

    interval_timer #(.LEN(FAST_BACKFLOW_CYC)) u_fast_bf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(fast_bf_run),
        .done(fast_bf_done)
    );

    interval_timer #(.LEN(INPUT_ON_CYC)) u_settle (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(settle_run),
        .done(settle_done)
    );

    interval_timer #(.LEN(UV_CYC)) u_uv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(uv_run),
        .done(uv_done)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Next-state logic for the output switch, faults and flags
    always_comb begin
        st_nxt = st_r;

        // Thermal flag with hysteresis: set at trip, clear once cooled
        if (thermal_trip_temp) begin
            st_nxt.thermal_r = 1'b1; // R17
        end else if (thermal_hysteresis) begin
            st_nxt.thermal_r = 1'b0; // R18
        end

        case (st_r.state_r)
            fault_seq_pkg::ST_ON: begin
                if (thermal_now) begin
                    st_nxt.state_r = is_latchoff ? fault_seq_pkg::ST_LATCHED
                                                 : fault_seq_pkg::ST_THERMAL; // R3 R17
                end else if (fast_trip_current) begin
                    st_nxt.state_r = fault_seq_pkg::ST_FAST_HOLD; // R5
                end else if (blank_done) begin
                    st_nxt.oc_fault_r = 1'b1;
                    if (is_latchoff) begin
                        st_nxt.state_r = fault_seq_pkg::ST_LATCHED; // R3
                    end else if (is_autoretry) begin
                        st_nxt.state_r = fault_seq_pkg::ST_RETRY; // R23
                    end
                end else if (!overcurrent) begin
                    st_nxt.oc_fault_r = 1'b0; // R2
                end
            end
            fault_seq_pkg::ST_FAST_HOLD: begin
                if (thermal_now) begin
                    st_nxt.state_r = is_latchoff ? fault_seq_pkg::ST_LATCHED
                                                 : fault_seq_pkg::ST_THERMAL;
                end else if (hold_done) begin
                    st_nxt.state_r = fault_seq_pkg::ST_ON; // R6
                end
            end
            fault_seq_pkg::ST_RETRY: begin
                if (thermal_now) begin
                    st_nxt.state_r = fault_seq_pkg::ST_THERMAL;
                end else if (retry_done) begin
                    st_nxt.state_r = fault_seq_pkg::ST_ON; // R19 R23
                end
            end
            fault_seq_pkg::ST_THERMAL: begin
                if (!thermal_now) begin
                    st_nxt.state_r = is_autoretry ? fault_seq_pkg::ST_RETRY
                                                  : fault_seq_pkg::ST_ON; // R19 R20
                end
            end
            fault_seq_pkg::ST_LATCHED: begin
                st_nxt.state_r = fault_seq_pkg::ST_LATCHED; // R4
            end
            default: begin
                st_nxt.state_r = fault_seq_pkg::ST_ON;
            end
        endcase

        // Enable low clears the latch and the overcurrent fault
        if (!enable) begin
            st_nxt.state_r = fault_seq_pkg::ST_ON; // R4
            st_nxt.oc_fault_r = 1'b0;
        end

        // Output switch only conducts in the on state and while enabled
        st_nxt.out_sw_r = enable && (st_nxt.state_r == fault_seq_pkg::ST_ON) &&
                          !thermal_trip_temp && !fast_trip_current; // R5 R17

        // Backflow fault: either detector, cleared after the settle time
        if (slow_bf_done || fast_bf_done) begin
            st_nxt.rev_fault_r = 1'b1; // R8 R9
        end else if (settle_done) begin
            st_nxt.rev_fault_r = 1'b0; // R10
        end
        if (!REVERSE_BLOCK_EN) begin
            st_nxt.rev_fault_r = 1'b0; // R7
        end
        st_nxt.in_sw_r = enable && !(st_nxt.rev_fault_r && bf_present); // R10

        // Power-up under-voltage debounce, sticky once elapsed
        if (uv_done) begin
            st_nxt.uv_done_r = 1'b1; // R13 R14
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Fault outputs
    // ------------------------------------------------------------------
    // Any source keeps the alert asserted until all have cleared
    assign fault_any = st_r.oc_fault_r || startup_oc_fault || st_r.thermal_r ||
                       thermal_trip_temp || limit_set_resistor_low ||
                       (st_r.state_r == fault_seq_pkg::ST_LATCHED); // R25
    assign supply_fault = undervoltage_lockout || overvoltage_lockout || !st_r.uv_done_r; // R12 R13

    // Pin routing depends on the output configuration
    assign primary_fault = (output_config == fault_seq_pkg::CFG_TWO_OUTPUT) ?
                           (fault_any || st_r.rev_fault_r) : fault_any; // R11 R15
    assign secondary_fault = (output_config == fault_seq_pkg::CFG_TWO_OUTPUT) ?
                             supply_fault : st_r.rev_fault_r; // R12 R15

    open_drain_driver u_primary ( // R16
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .fault(primary_fault),
        .pin_o(primary_alert_n_o),
        .pin_oe(primary_alert_n_oe)
    );

    open_drain_driver u_secondary ( // R16
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .fault(secondary_fault),
        .pin_o(secondary_alert_n_o),
        .pin_oe(secondary_alert_n_oe)
    );

    assign input_switch = st_r.in_sw_r;
    assign output_switch = st_r.out_sw_r;

endmodule // protection_fault_sequencer

`default_nettype wire

// *** tb_top.sv ***
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic enable = 1'b1;
    logic [1:0] limit_mode_select = 2'h0;
    logic output_config = 1'b0;
    logic overcurrent = 1'b0;
    logic fast_trip_current = 1'b0;
    logic thermal_trip_temp = 1'b0;
    logic thermal_hysteresis = 1'b1;
    logic slow_backflow_threshold = 1'b0;
    logic fast_backflow_threshold = 1'b0;
    logic limit_set_resistor_low = 1'b0;
    logic startup_oc_fault = 1'b0;
    logic undervoltage_lockout = 1'b0;
    logic overvoltage_lockout = 1'b0;
    logic input_switch, output_switch, primary_alert_n_o, primary_alert_n_oe;
    logic secondary_alert_n_o, secondary_alert_n_oe, primary_level, secondary_level;
    int err_total = 0;
    int check_count = 0;

    protection_fault_sequencer #(.BLANK_CYC(8), .FAST_HOLDOFF_CYC(16), .RETRY_CYC(20), .SLOW_BACKFLOW_CYC(6),
        .FAST_BACKFLOW_CYC(2), .INPUT_ON_CYC(10), .UV_CYC(30)) DUT (.*);

    fault_host host_i (.*);

    // ----
    // Helpers
    // ----
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic see(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return output_switch;
            1: return input_switch;
            2: return primary_level;
            default: return secondary_level;
        endcase
    endfunction

    // Waits for a level and judges how many cycles it took
    task automatic wt(input int k, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (pick(k) !== v && n < hi + 2) begin
            see(1);
            n++;
        end
        chk(n >= lo && n <= hi, 1'b1);
    endtask

    task automatic mode(input logic [1:0] m);
        tk(1);
        enable <= 1'b0;
        limit_mode_select <= m;
        tk(2);
        enable <= 1'b1;
    endtask

    task automatic hot(input logic h);
        tk(1);
        thermal_trip_temp <= h;
        thermal_hysteresis <= ~h;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_power();
        see(5);
        chk(secondary_level, 1'b0);
        wt(3, 1'b1, 24, 34);
    endtask

    task automatic t_fast();
        tk(1);
        fast_trip_current <= 1'b1;
        see(1);
        chk(output_switch, 1'b0);
        chk(input_switch, 1'b1);
        tk(1);
        fast_trip_current <= 1'b0;
        see(8);
        chk(output_switch, 1'b0);
        wt(0, 1'b1, 6, 13);
    endtask

    task automatic t_latch();
        mode(2'h1);
        overcurrent <= 1'b1;
        tk(5);
        overcurrent <= 1'b0;
        see(4);
        chk(output_switch, 1'b1);
        chk(primary_level, 1'b1);
        tk(1);
        overcurrent <= 1'b1;
        see(8);
        chk(output_switch, 1'b1);
        wt(0, 1'b0, 1, 4);
        see(2);
        chk(primary_level, 1'b0);
        tk(1);
        overcurrent <= 1'b0;
        see(30);
        chk(output_switch, 1'b0);
        mode(2'h1);
        see(3);
        chk(output_switch, 1'b1);
        chk(primary_level, 1'b1);
    endtask

    task automatic t_thermal();
        mode(2'h0);
        hot(1'b1);
        see(1);
        chk(output_switch, 1'b0);
        see(1);
        chk(primary_level, 1'b0);
        hot(1'b0);
        see(2);
        chk(output_switch, 1'b1);
        mode(2'h2);
        hot(1'b1);
        hot(1'b0);
        see(10);
        chk(output_switch, 1'b0);
        wt(0, 1'b1, 8, 18);
        mode(2'h1);
        hot(1'b1);
        hot(1'b0);
        see(25);
        chk(output_switch, 1'b0);
        chk(primary_level, 1'b0);
        mode(2'h0);
    endtask

    task automatic t_back();
        tk(1);
        slow_backflow_threshold <= 1'b1;
        see(5);
        chk(input_switch, 1'b1);
        see(4);
        chk(input_switch, 1'b0);
        chk(output_switch, 1'b1);
        chk(primary_level, 1'b0);
        tk(1);
        slow_backflow_threshold <= 1'b0;
        see(2);
        chk(input_switch, 1'b1);
        wt(2, 1'b1, 6, 16);
        tk(1);
        fast_backflow_threshold <= 1'b1;
        see(5);
        chk(input_switch, 1'b0);
        tk(1);
        fast_backflow_threshold <= 1'b0;
        wt(2, 1'b1, 8, 20);
    endtask

    task automatic t_config();
        tk(1);
        output_config <= 1'b1;
        slow_backflow_threshold <= 1'b1;
        see(10);
        chk(secondary_level, 1'b0);
        chk(primary_level, 1'b1);
        tk(1);
        slow_backflow_threshold <= 1'b0;
        wt(3, 1'b1, 6, 18);
        hot(1'b1);
        see(2);
        chk(primary_level, 1'b0);
        chk(secondary_level, 1'b1);
        hot(1'b0);
        tk(1);
        output_config <= 1'b0;
        undervoltage_lockout <= 1'b1;
        see(2);
        chk(secondary_level, 1'b0);
        tk(1);
        undervoltage_lockout <= 1'b0;
        see(3);
        chk(secondary_level, 1'b1);
        tk(1);
        overvoltage_lockout <= 1'b1;
        see(2);
        chk(secondary_level, 1'b0);
        tk(1);
        overvoltage_lockout <= 1'b0;
        limit_set_resistor_low <= 1'b1;
        see(2);
        chk(primary_level, 1'b0);
        tk(1);
        limit_set_resistor_low <= 1'b0;
        startup_oc_fault <= 1'b1;
        see(3);
        chk(primary_level, 1'b0);
        tk(1);
        startup_oc_fault <= 1'b0;
        see(3);
        chk(primary_level, 1'b1);
    endtask

    // Main sequence
    initial begin
        tk(20);
        rst_n <= 1'b1;
        t_power();
        t_fast();
        t_latch();
        t_thermal();
        t_back();
        t_config();
        print_verdict();
    end

    // Watchdog well past the expected run length
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
